// ### ppm_pkg.sv
// shared constants, types and helpers of the port performance monitor
package ppm_pkg;
    localparam int CNT_W = 32;
    localparam int DEPTH_W = 8;
    localparam int GRAN_W = 16;
    localparam int N_CNT = 2;
    localparam int N_DIR = 2;
    localparam int DIR_IN = 0;
    localparam int DIR_OUT = 1;
    localparam int N_REQ = 4;
    localparam int ID_W = 4;
    localparam int AGE_W = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 32'hffff_ffff;
    localparam logic [AGE_W-1:0] AGE_MAX = 8'hff;
    localparam logic [GRAN_W-1:0] GRAN_RST = 16'h0000;
    localparam logic [ID_W-1:0] ID_RST = 4'h0;
    localparam logic [N_REQ-1:0] GNT_RST = 4'h0;

    typedef enum logic [1:0] {
        CM_PKT_ANY = 2'h0,
        CM_PKT_PRIO = 2'h1,
        CM_WORD = 2'h2
    } ppm_cnt_mode_e;

    typedef enum logic [1:0] {
        ARB_FCFS = 2'h0,
        ARB_SP1 = 2'h1,
        ARB_SP2 = 2'h2
    } ppm_arb_mode_e;

    typedef enum logic [1:0] {
        SCH_OLDEST = 2'h1,
        SCH_HIPRI = 2'h2
    } ppm_sched_e;

    // saturating increment, holds at all ones
    function automatic logic [CNT_W-1:0] ppm_sat_inc(input logic [CNT_W-1:0] v,
                                                    input logic inc);
        return (inc && v != CNT_MAX) ? v + 32'h1 : v;
    endfunction
endpackage

// ### ppm_port_mon.sv
// per-port performance monitor, egress arbiter and transmit scheduler
`timescale 1ns/1ps
module ppm_port_mon
    import ppm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_pkt_done,
    input wire logic rx_pkt_retried,
    input wire logic [1:0] rx_pkt_prio,
    input wire logic rx_word,
    input wire logic tx_pkt_done,
    input wire logic tx_pkt_retried,
    input wire logic [1:0] tx_pkt_prio,
    input wire logic tx_word,
    input wire ppm_cnt_mode_e cnt_mode [N_CNT],
    input wire logic [1:0] cnt_prio [N_CNT],
    input wire logic cnt_dir [N_CNT],
    input wire logic [N_CNT-1:0] cnt_rd,
    input wire logic [N_CNT-1:0] cnt_wr,
    input wire logic [CNT_W-1:0] cnt_wdata,
    output logic [CNT_W-1:0] cnt_val [N_CNT],
    input wire logic [DEPTH_W-1:0] q_depth [N_DIR],
    input wire logic [DEPTH_W-1:0] q_level [N_DIR],
    input wire logic [GRAN_W-1:0] q_gran [N_DIR],
    input wire logic [CNT_W-1:0] q_limit [N_DIR],
    input wire logic [N_DIR-1:0] q_irq_en,
    input wire logic [N_DIR-1:0] q_pw_en,
    input wire logic [N_DIR-1:0] q_rd,
    input wire logic [N_DIR-1:0] q_wr,
    output logic [CNT_W-1:0] q_exc_cnt [N_DIR],
    output logic [CNT_W-1:0] q_per_cnt [N_DIR],
    output logic [N_DIR-1:0] q_irq,
    input wire logic [N_DIR-1:0] q_irq_clr,
    output logic port_write,
    input wire logic reorder_stall,
    input wire logic reorder_passed,
    input wire logic [CNT_W-1:0] reorder_thr,
    input wire logic reorder_rd,
    input wire logic reorder_wr,
    output logic [CNT_W-1:0] reorder_cnt,
    output logic reorder_irq,
    input wire logic reorder_irq_clr,
    input wire ppm_arb_mode_e arb_mode,
    input wire logic [N_REQ-1:0] arb_req,
    input wire logic [1:0] arb_prio [N_REQ],
    output logic [N_REQ-1:0] arb_gnt,
    input wire logic tx_start,
    input wire logic tx_retry,
    input wire logic [ID_W-1:0] tx_oldest_id,
    input wire logic [ID_W-1:0] tx_hipri_id,
    output logic [ID_W-1:0] tx_pick_id,
    input wire logic [DEPTH_W-1:0] buf_depth,
    input wire logic [DEPTH_W-1:0] buf_wm [3],
    output logic [3:0] buf_accept
);
    // ----------------------------------------
    // statistics counters
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_ff [N_CNT];
    logic [N_CNT-1:0] cnt_inc;

    for (genvar c = 0; c < N_CNT; c++) begin : g_cnt
        wire pkt = cnt_dir[c] ? tx_pkt_done : rx_pkt_done;
        wire rtry = cnt_dir[c] ? tx_pkt_retried : rx_pkt_retried;
        wire [1:0] prio = cnt_dir[c] ? tx_pkt_prio : rx_pkt_prio;
        wire word = cnt_dir[c] ? tx_word : rx_word;
        wire pkt_ok = pkt && !rtry;
        wire prio_ok = (cnt_mode[c] != CM_PKT_PRIO) || (prio == cnt_prio[c]);
        wire [CNT_W-1:0] base = cnt_rd[c] ? CNT_RST : cnt_ff[c];
        assign cnt_inc[c] = (cnt_mode[c] == CM_WORD) ? word : pkt_ok && prio_ok;
        always_ff @(posedge clk) begin
            if (srst) begin
                cnt_ff[c] <= CNT_RST;
            end else if (cnt_wr[c]) begin
                cnt_ff[c] <= cnt_wdata;
            end else begin
                cnt_ff[c] <= ppm_sat_inc(base, cnt_inc[c]);
            end
        end
        assign cnt_val[c] = cnt_ff[c];
    end

    // ----------------------------------------
    // queue watermark monitors and events
    // ----------------------------------------
    ppm_wm_if wif [N_DIR] ();
    logic [N_DIR-1:0] q_irq_ff;
    logic [N_DIR-1:0] hit;
    logic pw_ff;

    for (genvar d = 0; d < N_DIR; d++) begin : g_dir
        assign wif[d].depth = q_depth[d];
        assign wif[d].level = q_level[d];
        assign wif[d].gran = q_gran[d];
        assign wif[d].limit = q_limit[d];
        assign wif[d].rd = q_rd[d];
        assign wif[d].wr = q_wr[d];
        assign wif[d].wdata_exc = cnt_wdata;
        assign wif[d].wdata_per = cnt_wdata;
        assign q_exc_cnt[d] = wif[d].exc_cnt;
        assign q_per_cnt[d] = wif[d].per_cnt;
        assign hit[d] = wif[d].limit_hit;
        ppm_wm_mon u_mon (
            .clk(clk),
            .srst(srst),
            .w(wif[d])
        );
    end

    wire [N_DIR-1:0] q_irq_set = hit & q_irq_en;
    wire pw_set = |(hit & q_pw_en);

    always_ff @(posedge clk) begin
        if (srst) begin
            q_irq_ff <= '0;
            pw_ff <= 1'b0;
        end else begin
            q_irq_ff <= q_irq_set | (q_irq_ff & ~q_irq_clr);
            pw_ff <= pw_set;
        end
    end
    assign q_irq = q_irq_ff;
    assign port_write = pw_ff;

    // ----------------------------------------
    // reorder counter and interrupt
    // ----------------------------------------
    logic [CNT_W-1:0] reo_ff;
    logic reo_irq_ff;
    wire reo_evt = reorder_stall && reorder_passed;
    wire [CNT_W-1:0] reo_base = reorder_rd ? CNT_RST : reo_ff;
    wire reo_set = (reo_ff == reorder_thr) && (reorder_thr != CNT_RST);

    always_ff @(posedge clk) begin
        if (srst) begin
            reo_ff <= CNT_RST;
            reo_irq_ff <= 1'b0;
        end else begin
            reo_ff <= reorder_wr ? cnt_wdata : ppm_sat_inc(reo_base, reo_evt);
            reo_irq_ff <= reo_set || (reo_irq_ff && !reorder_irq_clr);
        end
    end
    assign reorder_cnt = reo_ff;
    assign reorder_irq = reo_irq_ff;

    // ----------------------------------------
    // fabric egress arbiter
    // ----------------------------------------
    logic [AGE_W-1:0] age_ff [N_REQ];
    logic [N_REQ-1:0] gnt_ff;
    logic [N_REQ-1:0] nxt_gnt;

    for (genvar r = 0; r < N_REQ; r++) begin : g_age
        always_ff @(posedge clk) begin
            if (srst || !arb_req[r] || gnt_ff[r]) begin
                age_ff[r] <= '0;
            end else if (age_ff[r] != AGE_MAX) begin
                age_ff[r] <= age_ff[r] + 8'h1;
            end
        end
    end

    // fcfs by age; sp1 by priority then age; sp2 by priority then index
    always_comb begin
        int best;
        logic better;
        best = -1;
        better = 1'b0;
        for (int i = 0; i < N_REQ; i++) begin
            if (best < 0) begin
                better = arb_req[i];
            end else if (arb_mode == ARB_FCFS) begin
                better = arb_req[i] && age_ff[i] > age_ff[best];
            end else if (arb_prio[i] != arb_prio[best]) begin
                better = arb_req[i] && arb_prio[i] > arb_prio[best];
            end else begin
                better = arb_req[i] && arb_mode == ARB_SP1 && age_ff[i] > age_ff[best];
            end
            if (better) begin
                best = i;
            end
        end
        nxt_gnt = '0;
        for (int i = 0; i < N_REQ; i++) begin
            nxt_gnt[i] = (best == i);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gnt_ff <= GNT_RST;
        end else begin
            gnt_ff <= nxt_gnt;
        end
    end
    assign arb_gnt = gnt_ff;

    // ----------------------------------------
    // transmit scheduler
    // ----------------------------------------
    ppm_sched_e sch_ff;
    ppm_sched_e nxt_sch;
    logic [ID_W-1:0] pick_ff;

    always_comb begin
        case (sch_ff)
            SCH_OLDEST: nxt_sch = tx_retry ? SCH_HIPRI : SCH_OLDEST;
            SCH_HIPRI: nxt_sch = (tx_start && !tx_retry) ? SCH_OLDEST : SCH_HIPRI;
            default: nxt_sch = SCH_OLDEST;
        endcase
    end

    wire [ID_W-1:0] nxt_pick = (nxt_sch == SCH_HIPRI) ? tx_hipri_id : tx_oldest_id;

    always_ff @(posedge clk) begin
        if (srst) begin
            sch_ff <= SCH_OLDEST;
            pick_ff <= ID_RST;
        end else begin
            sch_ff <= nxt_sch;
            pick_ff <= nxt_pick;
        end
    end
    assign tx_pick_id = pick_ff;

    // ----------------------------------------
    // buffer watermarks per priority
    // ----------------------------------------
    for (genvar p = 0; p < 3; p++) begin : g_wm
        assign buf_accept[p] = buf_depth < buf_wm[p];
    end
    assign buf_accept[3] = buf_depth != '1;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_rd_clear;
        @(posedge clk) disable iff (srst)
        cnt_rd[0] && !cnt_wr[0] && !cnt_inc[0] |=> cnt_val[0] == CNT_RST;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("counter not cleared by read");

    property p_sat;
        @(posedge clk) disable iff (srst)
        cnt_val[0] == CNT_MAX && !cnt_rd[0] && !cnt_wr[0] |=> cnt_val[0] == CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("counter wrapped");

    property p_retry;
        @(posedge clk) disable iff (srst)
        !cnt_dir[0] && cnt_mode[0] != CM_WORD && rx_pkt_retried && !cnt_rd[0] && !cnt_wr[0]
            |=> $stable(cnt_val[0]);
    endproperty
    a_retry: assert property (p_retry) else $error("retried packet counted");

    property p_prio;
        @(posedge clk) disable iff (srst)
        !cnt_dir[0] && cnt_mode[0] == CM_PKT_PRIO && rx_pkt_prio != cnt_prio[0]
            && !cnt_rd[0] && !cnt_wr[0] |=> $stable(cnt_val[0]);
    endproperty
    a_prio: assert property (p_prio) else $error("wrong priority counted");

    property p_word;
        @(posedge clk) disable iff (srst)
        !cnt_dir[0] && cnt_mode[0] == CM_WORD && rx_word && !cnt_rd[0] && !cnt_wr[0]
            && cnt_val[0] != CNT_MAX |=> cnt_val[0] == $past(cnt_val[0]) + 32'h1;
    endproperty
    a_word: assert property (p_word) else $error("word not counted");

    property p_reo_cnt;
        @(posedge clk) disable iff (srst)
        reorder_stall && reorder_passed && !reorder_rd && !reorder_wr && reorder_cnt != CNT_MAX
            |=> reorder_cnt == $past(reorder_cnt) + 32'h1;
    endproperty
    a_reo_cnt: assert property (p_reo_cnt) else $error("reorder not counted");

    property p_reo_irq;
        @(posedge clk) disable iff (srst)
        reorder_cnt == reorder_thr && reorder_thr != CNT_RST |=> reorder_irq;
    endproperty
    a_reo_irq: assert property (p_reo_irq) else $error("reorder interrupt missing");

    property p_irq_hold;
        @(posedge clk) disable iff (srst)
        q_irq[0] && !q_irq_clr[0] |=> q_irq[0];
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");

    property p_sched;
        @(posedge clk) disable iff (srst)
        tx_retry ##1 (tx_start && !tx_retry) |=> tx_pick_id == $past(tx_oldest_id);
    endproperty
    a_sched: assert property (p_sched) else $error("scheduler did not return to oldest");

    property p_accept;
        @(posedge clk) disable iff (srst)
        buf_depth >= buf_wm[0] |-> !buf_accept[0];
    endproperty
    a_accept: assert property (p_accept) else $error("low priority accepted over watermark");

    c_sat: cover property (@(posedge clk) disable iff (srst) cnt_val[0] == CNT_MAX);
    c_reo_irq: cover property (@(posedge clk) disable iff (srst) $rose(reorder_irq));
    c_retry: cover property (@(posedge clk) disable iff (srst) tx_retry ##1 tx_start);
    c_pw: cover property (@(posedge clk) disable iff (srst) port_write);
endmodule

// ### ppm_wm_if.sv
// per-direction queue watermark signals between top and monitor
`timescale 1ns/1ps
interface ppm_wm_if;
    import ppm_pkg::*;
    logic [DEPTH_W-1:0] depth;
    logic [DEPTH_W-1:0] level;
    logic [GRAN_W-1:0] gran;
    logic [CNT_W-1:0] limit;
    logic rd;
    logic wr;
    logic [CNT_W-1:0] wdata_exc;
    logic [CNT_W-1:0] wdata_per;
    logic [CNT_W-1:0] exc_cnt;
    logic [CNT_W-1:0] per_cnt;
    logic limit_hit;

    modport mon (input depth, level, gran, limit, rd, wr, wdata_exc, wdata_per,
                 output exc_cnt, per_cnt, limit_hit);
    modport ctl (output depth, level, gran, limit, rd, wr, wdata_exc, wdata_per,
                 input exc_cnt, per_cnt, limit_hit);
endinterface

// ### ppm_wm_mon.sv
// queue depth watermark monitor for one direction
`timescale 1ns/1ps
module ppm_wm_mon
    import ppm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    ppm_wm_if.mon w
);
    logic above_ff;
    logic [GRAN_W-1:0] tick_ff;
    logic [CNT_W-1:0] exc_ff;
    logic [CNT_W-1:0] per_ff;
    logic hit_ff;
    logic [CNT_W-1:0] nxt_exc;
    logic [CNT_W-1:0] nxt_per;
    logic [GRAN_W-1:0] nxt_tick;

    // ----------------------------------------
    // exceed detection and period timing
    // ----------------------------------------
    wire above = w.depth > w.level;
    wire rise = above && !above_ff;
    wire unit_done = above && (tick_ff >= w.gran);
    wire [CNT_W-1:0] exc_base = w.rd ? CNT_RST : exc_ff;
    wire [CNT_W-1:0] per_base = w.rd ? CNT_RST : per_ff;

    assign nxt_tick = !above ? GRAN_RST : (unit_done ? GRAN_RST : tick_ff + 16'h1);
    assign nxt_exc = w.wr ? w.wdata_exc : ppm_sat_inc(exc_base, rise);
    assign nxt_per = w.wr ? w.wdata_per : ppm_sat_inc(per_base, unit_done);

    always_ff @(posedge clk) begin
        if (srst) begin
            above_ff <= 1'b0;
            tick_ff <= GRAN_RST;
            exc_ff <= CNT_RST;
            per_ff <= CNT_RST;
            hit_ff <= 1'b0;
        end else begin
            above_ff <= above;
            tick_ff <= nxt_tick;
            exc_ff <= nxt_exc;
            per_ff <= nxt_per;
            hit_ff <= rise && !w.wr && exc_base == w.limit;
        end
    end

    assign w.exc_cnt = exc_ff;
    assign w.per_cnt = per_ff;
    assign w.limit_hit = hit_ff;
endmodule

// ### testbench.sv
// self-checking testbench of the port performance monitor
`timescale 1ns/1ps
module testbench;
    import ppm_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk, srst;
    logic rx_pkt_done, rx_pkt_retried, rx_word, tx_pkt_done, tx_pkt_retried, tx_word;
    logic [1:0] rx_pkt_prio, tx_pkt_prio;
    ppm_cnt_mode_e cnt_mode [N_CNT];
    logic [1:0] cnt_prio [N_CNT];
    logic cnt_dir [N_CNT];
    logic [N_CNT-1:0] cnt_rd, cnt_wr;
    logic [CNT_W-1:0] cnt_wdata, reorder_thr, reorder_cnt;
    logic [CNT_W-1:0] cnt_val [N_CNT];
    logic [DEPTH_W-1:0] q_depth [N_DIR];
    logic [DEPTH_W-1:0] q_level [N_DIR];
    logic [GRAN_W-1:0] q_gran [N_DIR];
    logic [CNT_W-1:0] q_limit [N_DIR];
    logic [CNT_W-1:0] q_exc_cnt [N_DIR];
    logic [CNT_W-1:0] q_per_cnt [N_DIR];
    logic [N_DIR-1:0] q_irq_en, q_pw_en, q_rd, q_wr, q_irq, q_irq_clr;
    logic port_write, reorder_stall, reorder_passed, reorder_rd, reorder_wr;
    logic reorder_irq, reorder_irq_clr, tx_start, tx_retry;
    ppm_arb_mode_e arb_mode;
    logic [N_REQ-1:0] arb_req, arb_gnt;
    logic [1:0] arb_prio [N_REQ];
    logic [ID_W-1:0] tx_oldest_id, tx_hipri_id, tx_pick_id;
    logic [DEPTH_W-1:0] buf_depth;
    logic [DEPTH_W-1:0] buf_wm [3];
    logic [3:0] buf_accept;
    int errors, num_checks, cycles;

    ppm_port_mon dut (
        .clk(clk), .srst(srst), .rx_pkt_done(rx_pkt_done), .rx_pkt_retried(rx_pkt_retried),
        .rx_pkt_prio(rx_pkt_prio), .rx_word(rx_word), .tx_pkt_done(tx_pkt_done),
        .tx_pkt_retried(tx_pkt_retried), .tx_pkt_prio(tx_pkt_prio), .tx_word(tx_word),
        .cnt_mode(cnt_mode), .cnt_prio(cnt_prio), .cnt_dir(cnt_dir), .cnt_rd(cnt_rd),
        .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata), .cnt_val(cnt_val), .q_depth(q_depth),
        .q_level(q_level), .q_gran(q_gran), .q_limit(q_limit), .q_irq_en(q_irq_en),
        .q_pw_en(q_pw_en), .q_rd(q_rd), .q_wr(q_wr), .q_exc_cnt(q_exc_cnt),
        .q_per_cnt(q_per_cnt), .q_irq(q_irq), .q_irq_clr(q_irq_clr), .port_write(port_write),
        .reorder_stall(reorder_stall), .reorder_passed(reorder_passed),
        .reorder_thr(reorder_thr), .reorder_rd(reorder_rd), .reorder_wr(reorder_wr),
        .reorder_cnt(reorder_cnt), .reorder_irq(reorder_irq),
        .reorder_irq_clr(reorder_irq_clr), .arb_mode(arb_mode), .arb_req(arb_req),
        .arb_prio(arb_prio), .arb_gnt(arb_gnt), .tx_start(tx_start), .tx_retry(tx_retry),
        .tx_oldest_id(tx_oldest_id), .tx_hipri_id(tx_hipri_id), .tx_pick_id(tx_pick_id),
        .buf_depth(buf_depth), .buf_wm(buf_wm), .buf_accept(buf_accept)
    );

    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    always #2 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_counters();
        cnt_mode[0] = CM_PKT_PRIO;
        cnt_prio[0] = 2'h2;
        cnt_dir[0] = 1'b0;
        cnt_mode[1] = CM_WORD;
        cnt_dir[1] = 1'b1;
        tick(1);
        rx_pkt_done = 1'b1;
        rx_pkt_prio = 2'h2;
        tx_word = 1'b1;
        tick(1);
        rx_pkt_prio = 2'h1;
        tick(1);
        rx_pkt_prio = 2'h2;
        rx_pkt_retried = 1'b1;
        tick(1);
        rx_pkt_done = 1'b0;
        rx_pkt_retried = 1'b0;
        tx_word = 1'b0;
        chk("prio counter", 32'h1, cnt_val[0]);
        chk("word counter", 32'h3, cnt_val[1]);
        cnt_rd[0] = 1'b1;
        chk("counter on read", 32'h1, cnt_val[0]);
        tick(1);
        cnt_rd[0] = 1'b0;
        chk("counter after read", 32'h0, cnt_val[0]);
        cnt_wdata = 32'hffff_fffe;
        cnt_wr = 2'b11;
        tick(1);
        cnt_wr = 2'b00;
        chk("written counter", 32'hffff_fffe, cnt_val[1]);
        chk("written packet counter", 32'hffff_fffe, cnt_val[0]);
        tx_word = 1'b1;
        rx_pkt_done = 1'b1;
        tick(3);
        tx_word = 1'b0;
        rx_pkt_done = 1'b0;
        chk("saturated counter", 32'hffff_ffff, cnt_val[1]);
        chk("saturated packet counter", 32'hffff_ffff, cnt_val[0]);
        cnt_mode[0] = CM_PKT_ANY;
        cnt_dir[0] = 1'b1;
        cnt_rd[0] = 1'b1;
        tick(1);
        cnt_rd[0] = 1'b0;
        tx_pkt_done = 1'b1;
        tx_pkt_prio = 2'h3;
        tick(1);
        tx_pkt_prio = 2'h0;
        tick(1);
        tx_pkt_retried = 1'b1;
        tick(1);
        tx_pkt_done = 1'b0;
        tx_pkt_retried = 1'b0;
        chk("any packet counter", 32'h2, cnt_val[0]);
        cnt_mode[0] = CM_WORD;
        cnt_dir[0] = 1'b0;
        cnt_rd[0] = 1'b1;
        tick(1);
        cnt_rd[0] = 1'b0;
        rx_word = 1'b1;
        tick(2);
        rx_word = 1'b0;
        chk("inbound word counter", 32'h2, cnt_val[0]);
    endtask

    task automatic t_watermark();
        q_level[0] = 8'h05;
        q_gran[0] = 16'h0001;
        q_irq_en = 2'b11;
        q_pw_en = 2'b01;
        q_depth[0] = 8'h06;
        q_depth[1] = 8'h06;
        tick(1);
        chk("exceed count", 32'h1, q_exc_cnt[0]);
        tick(1);
        chk("watermark irq", 32'h1, 32'(q_irq[0]));
        chk("port write", 32'h1, 32'(port_write));
        tick(1);
        chk("port write pulse", 32'h0, 32'(port_write));
        tick(5);
        q_depth[0] = 8'h00;
        q_depth[1] = 8'h00;
        tick(1);
        chk("exceed held", 32'h1, q_exc_cnt[0]);
        chk("period count", 32'h4, q_per_cnt[0]);
        chk("outbound irq", 32'h0, 32'(q_irq[1]));
        chk("outbound exceed count", 32'h0, q_exc_cnt[1]);
        chk("irq sticky", 32'h1, 32'(q_irq[0]));
        q_depth[0] = 8'h06;
        tick(1);
        q_depth[0] = 8'h00;
        tick(1);
        q_rd[0] = 1'b1;
        chk("second rise", 32'h2, q_exc_cnt[0]);
        tick(1);
        q_rd[0] = 1'b0;
        q_irq_clr[0] = 1'b1;
        chk("exceed after read", 32'h0, q_exc_cnt[0]);
        tick(1);
        q_irq_clr[0] = 1'b0;
        chk("irq cleared", 32'h0, 32'(q_irq[0]));
        cnt_wdata = 32'h0000_0007;
        q_wr[0] = 1'b1;
        tick(1);
        q_wr[0] = 1'b0;
        chk("written period", 32'h7, q_per_cnt[0]);
    endtask

    task automatic t_reorder();
        reorder_thr = 32'h2;
        reorder_stall = 1'b1;
        tick(1);
        chk("stall without pass", 32'h0, reorder_cnt);
        reorder_passed = 1'b1;
        tick(2);
        reorder_stall = 1'b0;
        reorder_passed = 1'b0;
        chk("reorder count", 32'h2, reorder_cnt);
        tick(2);
        chk("reorder irq", 32'h1, 32'(reorder_irq));
        reorder_rd = 1'b1;
        tick(1);
        reorder_rd = 1'b0;
        reorder_irq_clr = 1'b1;
        chk("reorder after read", 32'h0, reorder_cnt);
        tick(1);
        reorder_irq_clr = 1'b0;
        chk("reorder irq cleared", 32'h0, 32'(reorder_irq));
    endtask

    task automatic t_sched_arb();
        chk("pick oldest", 32'h3, 32'(tx_pick_id));
        tx_retry = 1'b1;
        tick(1);
        tx_retry = 1'b0;
        chk("pick high priority", 32'h9, 32'(tx_pick_id));
        tick(2);
        chk("high priority held", 32'h9, 32'(tx_pick_id));
        tx_start = 1'b1;
        tick(1);
        tx_start = 1'b0;
        tick(1);
        chk("back to oldest", 32'h3, 32'(tx_pick_id));
        tx_retry = 1'b1;
        tick(1);
        tx_retry = 1'b0;
        tx_start = 1'b1;
        chk("quick high priority", 32'h9, 32'(tx_pick_id));
        tick(1);
        tx_start = 1'b0;
        chk("oldest after quick start", 32'h3, 32'(tx_pick_id));
        arb_prio[1] = 2'h2;
        arb_mode = ARB_SP2;
        arb_req = 4'b0011;
        tick(2);
        chk("strict two grant", 32'h2, 32'(arb_gnt));
        arb_mode = ARB_SP1;
        tick(2);
        chk("strict one grant", 32'h2, 32'(arb_gnt));
        arb_prio[1] = 2'h0;
        arb_mode = ARB_SP2;
        tick(2);
        chk("strict two tie grant", 32'h1, 32'(arb_gnt));
        arb_mode = ARB_SP1;
        tick(2);
        chk("strict one age grant", 32'h2, 32'(arb_gnt));
        arb_prio[1] = 2'h2;
        arb_mode = ARB_FCFS;
        tick(1);
        chk("fcfs oldest grant", 32'h1, 32'(arb_gnt));
        arb_mode = ARB_FCFS;
        arb_req = 4'b0100;
        tick(2);
        chk("fcfs grant", 32'h4, 32'(arb_gnt));
        arb_req = 4'b0000;
    endtask

    task automatic t_buffer();
        buf_wm[0] = 8'h02;
        buf_wm[1] = 8'h04;
        buf_wm[2] = 8'h06;
        buf_depth = 8'h03;
        tick(1);
        chk("accept mid", 32'he, 32'(buf_accept));
        buf_depth = 8'h01;
        tick(1);
        chk("accept low", 32'hf, 32'(buf_accept));
        buf_depth = 8'hff;
        tick(1);
        chk("accept full", 32'h0, 32'(buf_accept));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        errors = 0;
        num_checks = 0;
        cycles = 0;
        {rx_pkt_done, rx_pkt_retried, rx_word, tx_pkt_done, tx_pkt_retried, tx_word} = '0;
        {rx_pkt_prio, tx_pkt_prio, cnt_rd, cnt_wr, cnt_wdata} = '0;
        {q_irq_en, q_pw_en, q_rd, q_wr, q_irq_clr, reorder_thr} = '0;
        {reorder_stall, reorder_passed, reorder_rd, reorder_wr, reorder_irq_clr} = '0;
        {tx_start, tx_retry, arb_req, buf_depth} = '0;
        arb_mode = ARB_FCFS;
        tx_oldest_id = 4'h3;
        tx_hipri_id = 4'h9;
        foreach (cnt_mode[i]) begin
            cnt_mode[i] = CM_PKT_ANY;
            cnt_prio[i] = 2'h0;
            cnt_dir[i] = 1'b0;
        end
        foreach (q_depth[i]) begin
            q_depth[i] = 8'h00;
            q_level[i] = 8'h80;
            q_gran[i] = 16'h0000;
            q_limit[i] = 32'h0;
        end
        foreach (arb_prio[i]) begin
            arb_prio[i] = 2'h0;
        end
        foreach (buf_wm[i]) begin
            buf_wm[i] = 8'h10;
        end
        tick(10);
        srst = 1'b0;
        t_counters();
        t_watermark();
        t_reorder();
        t_sched_arb();
        t_buffer();
        stop_test();
    end
endmodule
